// *** core/mbaar_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module mbaar_core
  import mbaar_pkg::*;
#(
  parameter logic [7:0] DEVICE_CLASS = 8'h5a,  // Arbitrary value.
  parameter int         WAIT_CYC     = MAC_WAIT_CYC
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            bus_reset,
  input  wire logic            rx_valid,
  input  wire logic [7:0]      rx_data,
  output logic                 tx_valid,
  input  wire logic            tx_ready,
  output logic      [7:0]      tx_data,
  output logic      [7:0]      mem_addr,
  input  wire logic [7:0]      mem_rdata,
  input  wire logic [7:0][7:0] scratch_bytes,
  input  wire logic [5:0][7:0] serial_bytes,
  input  wire logic            copy_start,
  input  wire logic [15:0]     copy_addr,
  output logic      [159:0]    mac_value,
  output logic                 mac_done
);

  typedef struct packed {
    mbaar_state_t     state;
    logic             op_copy;
    logic [15:0]      addr;
    logic [5:0]       ld_cnt;
    logic [31:0][7:0] pg;
    logic [7:0][7:0]  sec;
    logic [4:0]       idx;
    logic [15:0]      crc;
    logic [31:0]      wait_cnt;
    logic             busy;
    logic [6:0]       rnd;
    logic [31:0]      a, b, c, d, e;
    logic [15:0][31:0] w;
    logic [159:0]     mac;
    logic             done;
    logic [7:0]       mem_addr;
  } mbaar_core_state_t;

  mbaar_core_state_t st_reg;
  mbaar_core_state_t st_next;
  logic [511:0]      msg_vec;
  logic [159:0]      mac_vec;
  logic              push_valid;
  logic              push_ready;
  logic [7:0]        push_data;
  logic              start_hash;
  logic [31:0]       tmp, w_new;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] din);
    logic [15:0] r;
    r = crc ^ {8'h00, din};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction : crc_byte

  function automatic logic [7:0] fetch_addr(input logic [1:0] page, input logic [5:0] cnt);
    fetch_addr = cnt[5] ? {SECRET_BASE[7:3], cnt[2:0]} : {1'b0, page, cnt[4:0]};
  endfunction : fetch_addr

  function automatic logic [31:0] sha_f(input logic [6:0] t, input logic [31:0] b,
                                        input logic [31:0] c, input logic [31:0] d);
    sha_f = (t < 7'd20) ? ((b & c) | (~b & d)) :
            (t >= 7'd40 && t < 7'd60) ? ((b & c) | (b & d) | (c & d)) : (b ^ c ^ d);
  endfunction : sha_f

  function automatic logic [31:0] sha_k(input logic [6:0] t);
    sha_k = (t < 7'd20) ? K_0 : (t < 7'd40) ? K_1 : (t < 7'd60) ? K_2 : K_3;
  endfunction : sha_k

  // Byte 0 of the result lands in bits 31:24 of word 0.
  function automatic logic [511:0] build_msg(input logic op_copy,
                                             input logic [15:0] addr,
                                             input logic [31:0][7:0] pg,
                                             input logic [7:0][7:0] sec,
                                             input logic [7:0][7:0] sp,
                                             input logic [5:0][7:0] sn);
    logic [0:63][7:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i]      = sec[i];
      m[48 + i] = sec[4 + i];
    end
    for (int i = 0; i < 32; i++) begin
      m[4 + i] = pg[i];
    end
    if (op_copy) begin
      for (int i = 0; i < 8; i++) begin
        m[32 + i] = sp[i];
      end
      m[52:54] = {FILL_BYTE, FILL_BYTE, FILL_BYTE};
      m[40]    = {MARK_COPY, addr[8:5]};
    end else begin
      m[36:39] = {FILL_BYTE, FILL_BYTE, FILL_BYTE, FILL_BYTE};
      m[52:54] = {sp[4], sp[5], sp[6]};
      m[40]    = {MARK_READ, addr[8:5]};
    end
    m[55] = PAD_BYTE;
    m[41] = DEVICE_CLASS;
    for (int i = 0; i < 6; i++) begin
      m[42 + i] = sn[i];
    end
    m[56:63] = {ZERO_BYTE, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE,
                ZERO_BYTE, ZERO_BYTE, LEN_HI_BYTE, LEN_LO_BYTE};
    build_msg = m;
  endfunction : build_msg

  assign msg_vec   = build_msg(st_reg.op_copy, st_reg.addr, st_reg.pg, st_reg.sec,
                               scratch_bytes, serial_bytes);
  assign mac_vec   = {st_reg.a, st_reg.b, st_reg.c, st_reg.d, st_reg.e};
  assign mem_addr  = st_reg.mem_addr;
  assign mac_value = st_reg.mac;
  assign mac_done  = st_reg.done;
  assign tmp   = {st_reg.a[26:0], st_reg.a[31:27]} + sha_f(st_reg.rnd, st_reg.b, st_reg.c,
                 st_reg.d) + st_reg.w[0] + sha_k(st_reg.rnd) + st_reg.e;
  assign w_new = st_reg.w[13] ^ st_reg.w[8] ^ st_reg.w[2] ^ st_reg.w[0];

  always_comb begin
    st_next    = st_reg;
    st_next.done = 1'b0;
    push_valid = 1'b0;
    push_data  = ZERO_BYTE;
    start_hash = 1'b0;
    if (st_reg.busy) begin
      st_next.e = st_reg.d;
      st_next.d = st_reg.c;
      st_next.c = {st_reg.b[1:0], st_reg.b[31:2]};
      st_next.b = st_reg.a;
      st_next.a = tmp;
      st_next.w = {w_new[30:0], w_new[31], st_reg.w[15:1]};
      st_next.rnd  = st_reg.rnd + 7'd1;
      st_next.busy = (st_reg.rnd != ROUND_LAST);
    end
    case (st_reg.state)
      S_IDLE: begin
        if (copy_start) begin
          st_next.op_copy  = 1'b1;
          st_next.addr     = copy_addr;
          st_next.ld_cnt   = '0;
          st_next.mem_addr = fetch_addr(copy_addr[6:5], 6'd0);
          st_next.state    = S_LOAD;
        end else if (rx_valid && rx_data == CMD_AUTH_READ) begin
          st_next.op_copy = 1'b0;
          st_next.crc     = crc_byte(CRC_INIT, rx_data);
          st_next.state   = S_ADDR_LO;
        end
      end
      S_ADDR_LO: begin
        if (rx_valid) begin
          st_next.addr[7:0] = rx_data;
          st_next.crc       = crc_byte(st_reg.crc, rx_data);
          st_next.state     = S_ADDR_HI;
        end
      end
      S_ADDR_HI: begin
        if (rx_valid) begin
          st_next.addr[15:8] = rx_data;
          st_next.crc        = crc_byte(st_reg.crc, rx_data);
          if ({rx_data, st_reg.addr[7:0]} < PAGE_LIMIT) begin
            st_next.ld_cnt   = '0;
            st_next.mem_addr = fetch_addr(st_reg.addr[6:5], 6'd0);
            st_next.state    = S_LOAD;
          end else begin
            st_next.state = S_IDLE;
          end
        end
      end
      S_LOAD: begin
        if (st_reg.ld_cnt[5]) begin
          st_next.sec[st_reg.ld_cnt[2:0]] = mem_rdata;
        end else begin
          st_next.pg[st_reg.ld_cnt[4:0]] = mem_rdata;
        end
        if (st_reg.ld_cnt == LOAD_LAST) begin
          st_next.idx   = st_reg.addr[4:0];
          st_next.state = st_reg.op_copy ? S_COPY_START : S_SEND_DATA;
        end else begin
          st_next.ld_cnt   = st_reg.ld_cnt + 6'd1;
          st_next.mem_addr = fetch_addr(st_reg.addr[6:5], st_reg.ld_cnt + 6'd1);
        end
      end
      S_COPY_START: begin
        start_hash    = 1'b1;
        st_next.state = S_COPY_HASH;
      end
      S_COPY_HASH: begin
        if (!st_reg.busy) begin
          st_next.mac   = mac_vec;
          st_next.done  = 1'b1;
          st_next.state = S_IDLE;
        end
      end
      S_SEND_DATA: begin
        push_valid = 1'b1;
        push_data  = st_reg.pg[st_reg.idx];
        if (push_ready) begin
          st_next.crc = crc_byte(st_reg.crc, push_data);
          st_next.idx = st_reg.idx + 5'd1;
          if (st_reg.idx == PAGE_LAST) begin
            st_next.state = S_SEND_FILL;
          end
        end
      end
      S_SEND_FILL: begin
        push_valid = 1'b1;
        push_data  = FILL_BYTE;
        if (push_ready) begin
          st_next.crc   = crc_byte(st_reg.crc, push_data);
          st_next.idx   = '0;
          st_next.state = S_SEND_CRC;
        end
      end
      S_SEND_CRC, S_SEND_MCRC: begin
        push_valid = 1'b1;
        push_data  = st_reg.idx[0] ? ~st_reg.crc[15:8] : ~st_reg.crc[7:0];
        if (push_ready) begin
          st_next.idx = st_reg.idx + 5'd1;
          if (st_reg.idx[0] && st_reg.state == S_SEND_MCRC) begin
            st_next.state = S_PATTERN;
          end else if (st_reg.idx[0]) begin
            start_hash       = 1'b1;
            st_next.wait_cnt = 32'(WAIT_CYC);
            st_next.state    = S_WAIT_MAC;
          end
        end
      end
      S_WAIT_MAC: begin
        if (st_reg.wait_cnt != '0) begin
          st_next.wait_cnt = st_reg.wait_cnt - 32'd1;
        end else if (!st_reg.busy) begin
          st_next.mac   = mac_vec;
          st_next.idx   = '0;
          st_next.crc   = CRC_INIT;
          st_next.state = S_SEND_MAC;
        end
      end
      S_SEND_MAC: begin
        push_valid = 1'b1;
        push_data  = st_reg.mac[{st_reg.idx, 3'b000} +: 8];
        if (push_ready) begin
          st_next.crc = crc_byte(st_reg.crc, push_data);
          st_next.idx = st_reg.idx + 5'd1;
          if (st_reg.idx == MAC_LAST) begin
            st_next.idx   = '0;
            st_next.state = S_SEND_MCRC;
          end
        end
      end
      S_PATTERN: begin
        push_valid = 1'b1;
        push_data  = PATTERN_BYTE;
      end
      default: begin
        st_next.state = S_IDLE;
      end
    endcase
    if (start_hash) begin
      st_next.busy = 1'b1;
      st_next.rnd  = '0;
      st_next.a    = H_A;
      st_next.b    = H_B;
      st_next.c    = H_C;
      st_next.d    = H_D;
      st_next.e    = H_E;
      for (int t = 0; t < 16; t++) begin
        st_next.w[t] = msg_vec[511 - 32 * t -: 32];
      end
    end
    if (bus_reset) begin
      st_next.state = S_IDLE;
      st_next.busy  = 1'b0;
      push_valid    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  mbaar_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .flush     (bus_reset),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  a_msg_trailer: assert property (@(posedge ref_clk) disable iff (rst)
    msg_vec[63:0] == {32'h00000000, 24'h000001, LEN_LO_BYTE}) else $error("trailer words wrong");
  a_secret_fetch: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.state == S_LOAD && st_reg.ld_cnt == 6'd32 |-> mem_addr == SECRET_BASE)
    else $error("secret fetched from wrong address");
  a_marker_byte: assert property (@(posedge ref_clk) disable iff (rst)
    msg_vec[191:184] == {(st_reg.op_copy ? MARK_COPY : MARK_READ), st_reg.addr[8:5]})
    else $error("page marker byte wrong");
  a_read_words: assert property (@(posedge ref_clk) disable iff (rst)
    !st_reg.op_copy |-> msg_vec[223:192] == 32'hffffffff && msg_vec[71:64] == PAD_BYTE)
    else $error("read block filler wrong");
  a_cmd_start: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.state == S_IDLE && !copy_start && !bus_reset && rx_valid
    && rx_data == CMD_AUTH_READ |=> st_reg.state == S_ADDR_LO) else $error("command not taken");
  a_bad_target: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.state == S_ADDR_HI && rx_valid && (rx_data != 8'h00 || st_reg.addr[7])
    |=> st_reg.state == S_IDLE ##1 !push_valid) else $error("invalid target not refused");
  a_fill_order: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.state == S_SEND_FILL && push_ready && !bus_reset
    |-> push_data == FILL_BYTE ##1 (st_reg.state == S_SEND_CRC && st_reg.idx == 5'd0))
    else $error("filler byte not followed by crc");
  a_mac_wait: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(st_reg.state == S_SEND_MAC) |-> st_reg.wait_cnt == 32'd0 && !st_reg.busy)
    else $error("mac sent before wait over");
  a_mac_first: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.state == S_SEND_MAC && st_reg.idx == 5'd0 |-> push_data == st_reg.mac[7:0])
    else $error("mac byte order wrong");
  a_round_count: assert property (@(posedge ref_clk) disable iff (rst || bus_reset)
    st_reg.busy && st_reg.rnd == ROUND_LAST |=> !st_reg.busy && st_reg.rnd == 7'd80)
    else $error("round count wrong");
  a_pattern_out: assert property (@(posedge ref_clk) disable iff (rst)
    bus_reset |=> st_reg.state == S_IDLE) else $error("bus reset did not stop pattern");

endmodule : mbaar_core
`default_nettype wire

// *** core/mbaar_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module mbaar_fifo
  import mbaar_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
  } mbaar_fifo_state_t;

  mbaar_fifo_state_t f_reg;
  mbaar_fifo_state_t f_next;
  logic              do_push;
  logic              do_pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready  = (f_reg.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (f_reg.cnt != '0);
  assign out_data  = f_reg.mem[f_reg.rd];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  always_comb begin
    f_next = f_reg;
    if (do_push) begin
      f_next.mem[f_reg.wr] = in_data;
      f_next.wr = bump(f_reg.wr);
    end
    if (do_pop) begin
      f_next.rd = bump(f_reg.rd);
    end
    f_next.cnt = f_reg.cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    if (flush) begin
      f_next.rd  = '0;
      f_next.wr  = '0;
      f_next.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

endmodule : mbaar_fifo
`default_nettype wire

// *** core/mbaar_pkg.sv ***
package mbaar_pkg;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR_LO, S_ADDR_HI, S_LOAD, S_COPY_START, S_COPY_HASH, S_SEND_DATA,
    S_SEND_FILL, S_SEND_CRC, S_WAIT_MAC, S_SEND_MAC, S_SEND_MCRC, S_PATTERN
  } mbaar_state_t;

  localparam logic [7:0]  CMD_AUTH_READ = 8'ha5;
  localparam logic [7:0]  SECRET_BASE   = 8'h80;
  localparam logic [7:0]  FILL_BYTE     = 8'hff;
  localparam logic [7:0]  PAD_BYTE      = 8'h80;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [7:0]  LEN_HI_BYTE   = 8'h01;
  localparam logic [7:0]  LEN_LO_BYTE   = 8'hb8;
  localparam logic [7:0]  PATTERN_BYTE  = 8'haa;
  localparam logic [3:0]  MARK_COPY     = 4'h0;
  localparam logic [3:0]  MARK_READ     = 4'h4;
  localparam logic [15:0] PAGE_LIMIT    = 16'h0080;
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  localparam logic [15:0] CRC_INIT      = 16'h0000;
  localparam logic [5:0]  LOAD_LAST     = 6'd39;
  localparam logic [4:0]  PAGE_LAST     = 5'd31;
  localparam logic [4:0]  MAC_LAST      = 5'd19;
  localparam logic [6:0]  ROUND_LAST    = 7'd79;
  localparam logic [31:0] H_A           = 32'h67452301;
  localparam logic [31:0] H_B           = 32'hefcdab89;
  localparam logic [31:0] H_C           = 32'h98badcfe;
  localparam logic [31:0] H_D           = 32'h10325476;
  localparam logic [31:0] H_E           = 32'hc3d2e1f0;
  localparam logic [31:0] K_0           = 32'h5a827999;
  localparam logic [31:0] K_1           = 32'h6ed9eba1;
  localparam logic [31:0] K_2           = 32'h8f1bbcdc;
  localparam logic [31:0] K_3           = 32'hca62c1d6;
  localparam int          MAC_WAIT_US   = 2000;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MAC_WAIT_CYC  = MAC_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int          FIFO_DEPTH    = 32;
  localparam int          FIFO_WIDTH    = 8;

endpackage : mbaar_pkg

// *** dv/mbaar_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mbaar_master_model (
  input  wire logic       ref_clk,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // Sends bytes back to back, then scrambles the released data lines.
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= q[i];
      @(posedge ref_clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask : send

  // Takes one byte, optionally stalling first, within a bounded wait.
  task automatic recv(input int stall, input int lim, output logic [7:0] b, output bit ok,
                      output int n);
    if (stall > 0) begin
      tx_ready <= 1'b0;
      repeat (stall) @(posedge ref_clk);
    end
    tx_ready <= 1'b1;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (n < lim && !ok) begin
      @(negedge ref_clk);
      n++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        b = tx_data;
        ok = 1'b1;
        @(posedge ref_clk);
      end
    end
  endtask : recv
endmodule : mbaar_master_model
`default_nettype wire

// *** dv/mbaar_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin cmp_count++; if ((got) !== (want)) begin err_total++; $display("MISMATCH at %0t: got %0h expected %0h", $time, got, want); end end
module mbaar_tb_top
  import mbaar_pkg::*;
;
  localparam int         WAIT  = 200;
  localparam logic [7:0] CLASS = 8'h3c;  // Arbitrary value.
  logic                  ref_clk, rst, bus_reset, rx_valid, tx_valid, tx_ready;
  logic                  copy_start, mac_done;
  logic            [7:0] rx_data, tx_data, mem_addr, mem_rdata;
  logic       [7:0][7:0] scratch_bytes;
  logic       [5:0][7:0] serial_bytes;
  logic           [15:0] copy_addr;
  logic          [159:0] mac_value;
  logic            [7:0] mem [256];
  int                    err_total, cmp_count;

  always #5 ref_clk = ~ref_clk;
  assign mem_rdata = mem[mem_addr];

  mbaar_core #(.DEVICE_CLASS(CLASS), .WAIT_CYC(WAIT)) dut (
    .ref_clk(ref_clk), .rst(rst), .bus_reset(bus_reset), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .scratch_bytes(scratch_bytes),
    .serial_bytes(serial_bytes), .copy_start(copy_start), .copy_addr(copy_addr),
    .mac_value(mac_value), .mac_done(mac_done)
  );

  mbaar_master_model master (
    .ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data)
  );

  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc

  function automatic logic [159:0] sha(input logic [7:0] mb [64]);
    logic [31:0] w [80];
    logic [31:0] a, b, c, d, e, f, k, t;
    {a, b, c, d, e} = {H_A, H_B, H_C, H_D, H_E};
    for (int i = 0; i < 80; i++) begin
      if (i < 16) begin
        w[i] = {mb[4*i], mb[4*i+1], mb[4*i+2], mb[4*i+3]};
      end else begin
        t = w[i-3] ^ w[i-8] ^ w[i-14] ^ w[i-16];
        w[i] = {t[30:0], t[31]};
      end
      f = (i < 20) ? ((b & c) | (~b & d)) :
          (i >= 40 && i < 60) ? ((b & c) | (b & d) | (c & d)) : (b ^ c ^ d);
      k = (i < 20) ? K_0 : (i < 40) ? K_1 : (i < 60) ? K_2 : K_3;
      t = {a[26:0], a[31:27]} + f + w[i] + k + e;
      {e, d, c, b, a} = {d, c, b[1:0], b[31:2], a, t};
    end
    return {a, b, c, d, e};
  endfunction : sha

  function automatic logic [159:0] expect_mac(input bit rd, input logic [15:0] ad);
    logic [7:0] mb [64];
    int         p;
    p = {ad[6:5], 5'd0};
    for (int i = 0; i < 64; i++) begin
      mb[i] = 8'h00;
    end
    for (int i = 0; i < 4; i++) begin
      mb[i]    = mem[8'h80 + i];
      mb[48+i] = mem[8'h84 + i];
      mb[36+i] = rd ? 8'hff : scratch_bytes[4+i];
      mb[44+i] = serial_bytes[2+i];
      mb[52+i] = (i == 3) ? 8'h80 : rd ? scratch_bytes[4+i] : 8'hff;
    end
    for (int i = 0; i < 32; i++) begin
      mb[4+i] = (rd || i < 28) ? mem[p+i] : scratch_bytes[i-28];
    end
    mb[40] = {rd ? 4'h4 : 4'h0, ad[8:5]};
    mb[41] = CLASS;
    mb[42] = serial_bytes[0];
    mb[43] = serial_bytes[1];
    mb[62] = 8'h01;
    mb[63] = 8'hb8;
    return sha(mb);
  endfunction : expect_mac

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic get(input int stall, input int lim, input logic [7:0] want, output int n);
    logic [7:0] b;
    bit         ok;
    master.recv(stall, lim, b, ok, n);
    if (!ok) begin
      err_total++;
      $display("MISMATCH at %0t: no byte arrived", $time);
      conclude();
    end
    `CHK(b, want)
  endtask : get

  task automatic quiet(input int cyc);
    int seen;
    seen = 0;
    repeat (cyc) begin
      @(negedge ref_clk);
      if (tx_valid !== 1'b0) seen++;
    end
    @(posedge ref_clk);
    `CHK(seen, 0)
  endtask : quiet

  task automatic pulse_bus_reset();
    bus_reset <= 1'b1;
    @(posedge ref_clk);
    bus_reset <= 1'b0;
    @(posedge ref_clk);
  endtask : pulse_bus_reset

  task automatic auth_read(input logic [15:0] ad, input int stall);
    logic [15:0]  c;
    logic [159:0] mac;
    int           n;
    c = crc(crc(crc(16'h0000, 8'ha5), ad[7:0]), ad[15:8]);
    master.send('{8'ha5, ad[7:0], ad[15:8]});
    for (int i = ad[4:0]; i < 32; i++) begin
      get(stall, 400, mem[{ad[6:5], 5'd0} + i], n);
      c = crc(c, mem[{ad[6:5], 5'd0} + i]);
    end
    get(stall, 50, 8'hff, n);
    c = crc(c, 8'hff);
    get(stall, 50, ~c[7:0], n);
    get(stall, 50, ~c[15:8], n);
    mac = expect_mac(1'b1, ad);
    c = 16'h0000;
    for (int i = 0; i < 20; i++) begin
      get(0, WAIT + 500, mac[8*i +: 8], n);
      if (i == 0 && stall == 0) `CHK(n >= WAIT - 20 && n <= WAIT + 20, 1'b1)
      c = crc(c, mac[8*i +: 8]);
    end
    get(0, 50, ~c[7:0], n);
    get(0, 50, ~c[15:8], n);
    repeat (3) get(0, 50, 8'haa, n);
    pulse_bus_reset();
    quiet(20);
  endtask : auth_read

  task automatic s_copy();
    int n;
    copy_start <= 1'b1;
    copy_addr  <= 16'h0060;
    @(posedge ref_clk);
    copy_start <= 1'b0;
    for (n = 0; n < 300 && mac_done !== 1'b1; n++) @(negedge ref_clk);
    `CHK(n < 300, 1'b1)
    `CHK(mac_value, expect_mac(1'b0, 16'h0060))
    @(posedge ref_clk);
  endtask : s_copy

  task automatic s_full();
    scratch_bytes <= 64'h0b1c2d3e4f506172;
    @(posedge ref_clk);
    auth_read(16'h0040, 0);
  endtask : s_full

  task automatic s_mid();
    auth_read(16'h007d, 2);
  endtask : s_mid

  task automatic s_refuse();
    master.send('{8'ha5, 8'h80, 8'h00});
    quiet(100);
    master.send('{8'ha5, 8'h00, 8'h01});
    quiet(100);
  endtask : s_refuse

  task automatic s_other_cmd();
    master.send('{8'hf0, 8'h00, 8'h00});
    quiet(100);
  endtask : s_other_cmd

  task automatic s_abort();
    int n;
    master.send('{8'ha5, 8'h00, 8'h00});
    get(0, 400, mem[0], n);
    get(0, 50, mem[1], n);
    pulse_bus_reset();
    quiet(60);
  endtask : s_abort

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    bus_reset = 1'b0;
    copy_start = 1'b0;
    copy_addr = 16'h0000;
    err_total = 0;
    cmp_count = 0;
    scratch_bytes = 64'h1122334455667788;
    serial_bytes = 48'ha1b2c3d4e5f6;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    s_copy();
    s_full();
    s_mid();
    s_refuse();
    s_other_cmd();
    s_abort();
    conclude();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    $display("MISMATCH at %0t: run limit reached", $time);
    conclude();
  end
endmodule : mbaar_tb_top
`undef CHK
`default_nettype wire
